// ---- pkg/gah_pkg.sv ----
// constants, types and feature codes for the acceptor handshake and aux command block
package gah_pkg;
  // feature and command codes on feature_code
  localparam logic [4:0] FC_SOFT_RESET = 5'h00;
  localparam logic [4:0] FC_REL_DAC = 5'h01;
  localparam logic [4:0] FC_REL_RFD = 5'h02;
  localparam logic [4:0] FC_HOLD_ALL = 5'h03;
  localparam logic [4:0] FC_HOLD_END = 5'h04;
  localparam logic [4:0] FC_FORCE_TRIG = 5'h05;
  localparam logic [4:0] FC_RET_LOCAL = 5'h06;
  // feature vector after hardware reset: only soft reset set
  localparam logic [31:0] FEAT_RESET = 32'h0000_0001;
  // bus command bytes (seven bits, ATN true)
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [2:0] GRP_UNIV = 3'h1;
  localparam logic [2:0] GRP_LAG = 3'h2;
  localparam logic [2:0] GRP_TAG = 3'h4;
  localparam logic [2:0] GRP_SCG = 3'h6;
  // fifo shape
  localparam int FIFO_DEPTH = 8;
  localparam int RX_W = 9;
  // host aux command byte
  typedef struct packed {
    logic set_clear_bit;
    logic [1:0] spare;
    logic [4:0] feature_code;
  } gah_aux_cmd_s;
  // acceptor interrupt set, also used as mask
  typedef struct packed {
    logic get;
    logic my_address_irq;
    logic address_change_irq;
    logic dcas;
    logic secondary_addr_pass_irq;
    logic universal_cmd_irq;
    logic byte_in_irq;
    logic end_irq;
  } gah_irq_s;
  // received data byte with its end mark
  typedef struct packed {
    logic end_flag;
    logic [7:0] data;
  } gah_rx_s;
  // acceptor states, one-hot
  typedef enum logic [5:0] {
    ACC_IDLE = 6'h01,
    ACC_NRDY = 6'h02,
    ACC_READY = 6'h04,
    ACC_STROBE = 6'h08,
    ACC_HOLD = 6'h10,
    ACC_WAIT = 6'h20
  } gah_acc_e;
  // aux command sequencer states, one-hot
  typedef enum logic [2:0] {
    AUX_IDLE = 3'h1,
    AUX_WRITE = 3'h2,
    AUX_STROBE = 3'h4
  } gah_aux_e;
endpackage

// ---- design/gah_acceptor.sv ----
// acceptor handshake, aux command sequencer and received-byte fifo
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// small synchronous fifo with valid/ready on both sides
module gah_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // storage
  logic [AW-1:0] wp_r; // write pointer
  logic [AW-1:0] rp_r; // read pointer
  logic [AW:0] cnt_r; // fill level
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_r];
  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  // pointers and level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // gah_fifo

////////////////////////////////////////////////////////////////////////
// top: aux commands and acceptor handshake
module gah_acceptor (
  input wire logic clk,
  input wire logic rst,
  // host command side
  input wire logic aux_wr,
  input wire gah_pkg::gah_aux_cmd_s aux_cmd,
  input wire gah_pkg::gah_irq_s irq_mask,
  input wire logic [4:0] my_addr,
  // other local functions
  input wire logic cacs,
  input wire logic listen_active,
  // bus side
  input wire logic atn,
  input wire logic eoi,
  input wire logic dav,
  input wire logic [7:0] dio_in,
  output logic [7:0] dio_out,
  output logic rfd,
  output logic dac,
  // host data side
  output gah_pkg::gah_rx_s rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // status and events
  output gah_pkg::gah_irq_s irq_pulse,
  output logic trigger_out,
  output logic return_local,
  output logic sec_addr_valid,
  output logic soft_reset_cmd,
  output logic dac_holdoff_latch,
  output logic rfd_holdoff_data_latch,
  output logic rfd_holdoff_end_latch
);
  ////////////////////////////////////////////////////////////////////
  // decode helpers
  // command group of a seven-bit byte
  function automatic logic in_grp(input logic [6:0] b, input logic [2:0] g);
    in_grp = (b[6:4] == g) || (b[6:4] == (g | 3'h1));
  endfunction
  // address groups span 32 codes
  function automatic logic is_addr(input logic [6:0] b, input logic [2:0] g,
                                   input logic [4:0] a);
    is_addr = in_grp(b, g) && (b[4:0] == a);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // aux command sequencer
  gah_pkg::gah_aux_e aux_st_r; // sequencer state
  gah_pkg::gah_aux_cmd_s cmd_r; // captured command
  logic [31:0] feat_r; // clear/set feature states
  logic pend_r; // clear of an already false feature, any code
  logic sec_valid_r; // argument of last dac release
  logic ax_strobe;
  logic imm_rel_dac;
  logic imm_rel_rfd;
  logic sr;

  assign ax_strobe = (aux_st_r == gah_pkg::AUX_STROBE);
  // immediate commands only act in the strobe state
  assign imm_rel_dac = ax_strobe && (cmd_r.feature_code == gah_pkg::FC_REL_DAC);
  assign imm_rel_rfd = ax_strobe && (cmd_r.feature_code == gah_pkg::FC_REL_RFD);
  assign sr = feat_r[gah_pkg::FC_SOFT_RESET];

  // idle -> write -> strobe -> idle; writes outside idle are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_st_r <= gah_pkg::AUX_IDLE;
      cmd_r <= '0;
    end else begin
      case (aux_st_r)
        gah_pkg::AUX_IDLE: begin
          if (aux_wr) begin
            // host keeps writes five clocks apart
            aux_st_r <= gah_pkg::AUX_WRITE;
            cmd_r <= aux_cmd;
          end
        end
        gah_pkg::AUX_WRITE: aux_st_r <= gah_pkg::AUX_STROBE;
        gah_pkg::AUX_STROBE: aux_st_r <= gah_pkg::AUX_IDLE;
        default: aux_st_r <= gah_pkg::AUX_IDLE;
      endcase
    end
  end

  // clear/set features update in the write state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      feat_r <= gah_pkg::FEAT_RESET;
      pend_r <= 1'b0;
    end else if (aux_st_r == gah_pkg::AUX_WRITE) begin
      if (cmd_r.feature_code != gah_pkg::FC_REL_DAC &&
          cmd_r.feature_code != gah_pkg::FC_REL_RFD) begin
        feat_r[cmd_r.feature_code] <= cmd_r.set_clear_bit;
      end
      // clearing an already false force-trigger or return-local feature pulses it
      pend_r <= !cmd_r.set_clear_bit && !feat_r[cmd_r.feature_code];
    end
  end

  // dac release carries the secondary address verdict
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_valid_r <= 1'b0;
    end else if (imm_rel_dac) begin
      sec_valid_r <= cmd_r.set_clear_bit;
    end
  end

  logic pulse_trig;
  logic pulse_rtl;
  assign pulse_trig = ax_strobe && pend_r && (cmd_r.feature_code == gah_pkg::FC_FORCE_TRIG);
  assign pulse_rtl = ax_strobe && pend_r && (cmd_r.feature_code == gah_pkg::FC_RET_LOCAL);
  assign return_local = feat_r[gah_pkg::FC_RET_LOCAL] || pulse_rtl;
  assign sec_addr_valid = sec_valid_r;
  assign soft_reset_cmd = sr;

  ////////////////////////////////////////////////////////////////////
  // command decode and interrupt events
  gah_pkg::gah_acc_e st_r; // acceptor state
  gah_pkg::gah_acc_e st_nxt;
  gah_pkg::gah_irq_s ev; // events of this strobe cycle
  gah_pkg::gah_irq_s irq_r; // registered event pulses
  logic [6:0] cb;
  logic acc_strobe;
  logic dac_hold_req; // holdoff request, strobe only
  assign cb = dio_in[6:0];
  assign acc_strobe = (st_r == gah_pkg::ACC_STROBE);
  // events exist only in the strobe state
  always_comb begin
    ev = '0;
    if (acc_strobe) begin
      if (atn) begin
        ev.get = listen_active && (cb == gah_pkg::CMD_GET);
        ev.my_address_irq = is_addr(cb, gah_pkg::GRP_LAG, my_addr) ||
                            is_addr(cb, gah_pkg::GRP_TAG, my_addr);
        ev.address_change_irq = ev.my_address_irq;
        ev.dcas = (cb == gah_pkg::CMD_DCL) || (listen_active && cb == gah_pkg::CMD_SDC);
        ev.secondary_addr_pass_irq = in_grp(cb, gah_pkg::GRP_SCG);
        ev.universal_cmd_irq = in_grp(cb, gah_pkg::GRP_UNIV) && !ev.dcas;
      end else begin
        ev.byte_in_irq = 1'b1;
        ev.end_irq = eoi;
      end
    end
  end
  // holdoff request from unmasked command interrupts other than address change, strobe only
  assign dac_hold_req = (ev.get && irq_mask.get) ||
                (ev.my_address_irq && irq_mask.my_address_irq) ||
                (ev.dcas && irq_mask.dcas) ||
                (ev.universal_cmd_irq && irq_mask.universal_cmd_irq) ||
                (ev.secondary_addr_pass_irq && irq_mask.secondary_addr_pass_irq);

  // interrupt pulses, one clock after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= '0;
    end else begin
      irq_r <= ev;
    end
  end
  assign irq_pulse = irq_r;
  ////////////////////////////////////////////////////////////////////
  // holdoff latches; a set in the clearing cycle wins
  logic dac_l_r;
  logic hd_l_r;
  logic he_l_r;
  logic rx_pop;
  assign rx_pop = rx_valid && rx_ready;

  // dac holdoff: set by request, cleared by release or soft reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_l_r <= 1'b0;
    end else if (dac_hold_req) begin
      dac_l_r <= 1'b1;
    end else if (imm_rel_dac || sr) begin
      dac_l_r <= 1'b0;
    end
  end

  // data holdoff: read clears unless holding on every byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hd_l_r <= 1'b0;
    end else if (acc_strobe && !atn) begin
      hd_l_r <= 1'b1;
    end else if (sr || imm_rel_rfd || (rx_pop && !feat_r[gah_pkg::FC_HOLD_ALL])) begin
      hd_l_r <= 1'b0;
    end
  end

  // end holdoff: only rfd release or soft reset clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      he_l_r <= 1'b0;
    end else if (acc_strobe && !atn && eoi && feat_r[gah_pkg::FC_HOLD_END]) begin
      he_l_r <= 1'b1;
    end else if (sr || imm_rel_rfd) begin
      he_l_r <= 1'b0;
    end
  end

  assign dac_holdoff_latch = dac_l_r;
  assign rfd_holdoff_data_latch = hd_l_r;
  assign rfd_holdoff_end_latch = he_l_r;
  assign dio_out = 8'h00; // acceptor never drives data: null message

  ////////////////////////////////////////////////////////////////////
  // received bytes go through the fifo; a full fifo withholds rfd unless atn is true
  logic fifo_in_ready;
  logic rfd_ok;
  gah_pkg::gah_rx_s rx_in;
  assign rx_in = '{end_flag: eoi, data: dio_in};

  gah_fifo #(
    .W(gah_pkg::RX_W),
    .D(gah_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(rx_in),
    .in_valid(acc_strobe && !atn),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // commands bypass data holdoffs
  assign rfd_ok = atn || (!hd_l_r && !he_l_r && fifo_in_ready);

  ////////////////////////////////////////////////////////////////////
  // acceptor state machine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      gah_pkg::ACC_IDLE: if (atn || listen_active) st_nxt = gah_pkg::ACC_NRDY;
      gah_pkg::ACC_NRDY: begin
        if (!atn && !listen_active) st_nxt = gah_pkg::ACC_IDLE;
        else if (rfd_ok) st_nxt = gah_pkg::ACC_READY;
      end
      gah_pkg::ACC_READY: begin
        if (!atn && !listen_active) st_nxt = gah_pkg::ACC_IDLE;
        else if (dav) st_nxt = gah_pkg::ACC_STROBE;
        else if (!rfd_ok) st_nxt = gah_pkg::ACC_NRDY;
      end
      gah_pkg::ACC_STROBE: st_nxt = gah_pkg::ACC_HOLD;
      gah_pkg::ACC_HOLD: if (!dac_l_r) st_nxt = gah_pkg::ACC_WAIT;
      gah_pkg::ACC_WAIT: if (!dav) st_nxt = gah_pkg::ACC_NRDY;
      default: st_nxt = gah_pkg::ACC_IDLE;
    endcase
    // forced entry to idle from any state
    if (sr || cacs) begin
      st_nxt = gah_pkg::ACC_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= gah_pkg::ACC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // rfd true in idle and ready, dac true in idle and wait
  assign rfd = (st_r == gah_pkg::ACC_IDLE) || (st_r == gah_pkg::ACC_READY);
  assign dac = (st_r == gah_pkg::ACC_IDLE) || (st_r == gah_pkg::ACC_WAIT);

  ////////////////////////////////////////////////////////////////////
  // trigger: GET raises it on entry to the hold state and holds it through the hold state
  logic trig_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= ev.get || (trig_r && st_nxt == gah_pkg::ACC_HOLD);
    end
  end
  assign trigger_out = trig_r || feat_r[gah_pkg::FC_FORCE_TRIG] || pulse_trig;

  ////////////////////////////////////////////////////////////////////
  // checks
  AST_AUX_SEQ: assert property (@(posedge clk) disable iff (rst)
    aux_st_r == gah_pkg::AUX_WRITE |=> ax_strobe ##1 aux_st_r == gah_pkg::AUX_IDLE)
    else $error("aux sequencer left its fixed path");
  AST_CACS_IDLE: assert property (@(posedge clk) disable iff (rst)
    cacs |=> st_r == gah_pkg::ACC_IDLE && rfd && dac)
    else $error("acceptor active while controller active");
  AST_IRQ_STROBE: assert property (@(posedge clk) disable iff (rst)
    irq_r != '0 |-> $past(st_r) == gah_pkg::ACC_STROBE)
    else $error("interrupt outside strobe state");
  AST_HOLD_AFTER: assert property (@(posedge clk) disable iff (rst)
    acc_strobe && !sr && !cacs |=> st_r == gah_pkg::ACC_HOLD)
    else $error("hold did not follow strobe");
  AST_DAC_BLOCK: assert property (@(posedge clk) disable iff (rst)
    dac_hold_req && !cacs && !sr |=> dac_l_r && st_r == gah_pkg::ACC_HOLD ##1 (st_r != gah_pkg::ACC_WAIT))
    else $error("dac holdoff did not block");
  AST_TRIG_GET: assert property (@(posedge clk) disable iff (rst)
    ev.get && dac_l_r == 1'b0 && irq_mask.get && !sr && !cacs |=> trigger_out [*2])
    else $error("trigger not held after GET");
  AST_RFD_DATA: assert property (@(posedge clk) disable iff (rst)
    hd_l_r && !atn && st_r == gah_pkg::ACC_NRDY |=> st_r != gah_pkg::ACC_READY)
    else $error("ready despite data holdoff");
  AST_SR_CLEAR: assert property (@(posedge clk) disable iff (rst)
    sr |=> st_r == gah_pkg::ACC_IDLE && !hd_l_r && !he_l_r && !dac_l_r)
    else $error("soft reset left latches or state");
  AST_FTRIG_PULSE: assert property (@(posedge clk) disable iff (rst)
    aux_st_r == gah_pkg::AUX_WRITE && cmd_r.feature_code == gah_pkg::FC_FORCE_TRIG &&
    !cmd_r.set_clear_bit && !trigger_out |=> trigger_out ##1 !feat_r[gah_pkg::FC_FORCE_TRIG])
    else $error("force trigger pulse missing");
endmodule // gah_acceptor

// ---- bench/gah_talker.sv ----
// remote talker model that drives the three-wire handshake
`timescale 1ns/1ps
module gah_talker (
  input wire logic clk,
  input wire logic rfd,
  input wire logic dac,
  output logic atn,
  output logic eoi,
  output logic dav,
  output logic [7:0] dio_in
);
  // bus idle at start, data lines hold a non-zero filler
  initial begin
    atn = 1'b0;
    eoi = 1'b0;
    dav = 1'b0;
    dio_in = 8'hA5;
  end
  ////////////////////////////////////////////////////////////////
  // offer one byte once rfd is seen; ok low if refused or held
  task automatic send(input logic [7:0] b, input logic a, input logic e, input int slow, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    repeat (slow) @(posedge clk);
    #1;
    while (rfd !== 1'b1 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rfd !== 1'b1) return;
    atn = a;
    eoi = e;
    dio_in = b;
    @(posedge clk);
    #1;
    dav = 1'b1;
    finish(ok);
  endtask
  // keep dav up until dac is sampled high, then release the lines
  task automatic finish(output logic ok);
    int n;
    n = 0;
    while (dac !== 1'b1 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = (dac === 1'b1);
    if (!ok) return;
    @(posedge clk);
    #1;
    dav = 1'b0;
    eoi = 1'b0;
    dio_in = ~dio_in; // released lines must not show the old byte
  endtask
endmodule // gah_talker

// ---- bench/testbench.sv ----
// self-checking bench for the acceptor handshake and aux command block
`timescale 1ns/1ps
module testbench;
  logic clk, rst, aux_wr, cacs, listen_active, atn, eoi, dav, rfd, dac, rx_valid, rx_ready;
  logic trigger_out, return_local, sec_addr_valid, soft_reset_cmd;
  logic dac_holdoff_latch, rfd_holdoff_data_latch, rfd_holdoff_end_latch;
  gah_pkg::gah_aux_cmd_s aux_cmd;
  gah_pkg::gah_irq_s irq_mask, irq_pulse, seen;
  gah_pkg::gah_rx_s rx_data;
  logic [4:0] my_addr;
  logic [7:0] dio_in, dio_out, e;
  logic [7:0] b [8];
  logic [6:0] cl [6];
  logic ok, tp, rp;
  int n_mismatch, n_checks, seed, i, k;
  gah_acceptor gah_acceptor_i (.clk(clk), .rst(rst), .aux_wr(aux_wr), .aux_cmd(aux_cmd), .irq_mask(irq_mask),
    .my_addr(my_addr), .cacs(cacs), .listen_active(listen_active), .atn(atn), .eoi(eoi), .dav(dav),
    .dio_in(dio_in), .dio_out(dio_out), .rfd(rfd), .dac(dac), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .irq_pulse(irq_pulse), .trigger_out(trigger_out), .return_local(return_local),
    .sec_addr_valid(sec_addr_valid), .soft_reset_cmd(soft_reset_cmd), .dac_holdoff_latch(dac_holdoff_latch),
    .rfd_holdoff_data_latch(rfd_holdoff_data_latch), .rfd_holdoff_end_latch(rfd_holdoff_end_latch));
  gah_talker gah_talker_i (.clk(clk), .rfd(rfd), .dac(dac), .atn(atn), .eoi(eoi), .dav(dav), .dio_in(dio_in));
  ////////////////////////////////////////////////////////////////
  // clock and sticky record of the one-cycle event pulses
  always #10 clk = ~clk;
  always @(posedge clk) seen <= seen | irq_pulse;
  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one aux write, capture outputs in the strobe cycle, keep five-clock spacing
  task automatic aux(input logic [4:0] code, input logic sc);
    aux_cmd = '{sc, 2'h0, code};
    aux_wr = 1'b1;
    @(posedge clk);
    #1;
    aux_wr = 1'b0;
    @(posedge clk);
    #1;
    tp = trigger_out;
    rp = return_local;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // read the fifo head, then let an edge pass with ready low
  task automatic pop(input logic [8:0] exp);
    check(rx_valid, 1'b1, "rx valid");
    check(rx_data, exp, "rx data");
    rx_ready = 1'b1;
    @(posedge clk);
    #1;
    rx_ready = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // hardware reset, then idle values
  task automatic do_reset;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    check({soft_reset_cmd, rfd, dac, trigger_out, return_local, dac_holdoff_latch, rfd_holdoff_data_latch,
      rfd_holdoff_end_latch, rx_valid}, 9'h1C0, "reset state");
  endtask
  // event expected from a command byte
  function automatic logic [7:0] irq_of(input logic [6:0] c);
    if (c == gah_pkg::CMD_GET) return 8'h80;
    if (c == gah_pkg::CMD_DCL || c == gah_pkg::CMD_SDC) return 8'h10;
    if (c[6:4] == 3'h1) return 8'h04;
    if (c[6:5] == 2'h3) return 8'h08;
    return 8'h40;
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    clk = 0;
    rst = 1;
    aux_wr = 0;
    aux_cmd = '0;
    irq_mask = 8'hFF;
    my_addr = 5'h03;
    cacs = 0;
    listen_active = 1;
    rx_ready = 0;
    seen = '0;
    seed = 6;
    cl = '{7'h08, 7'h14, 7'h04, 7'h11, 7'h60, 7'h23};
    do_reset();
    aux(gah_pkg::FC_SOFT_RESET, 1'b0);
    check(soft_reset_cmd, 1'b0, "soft reset clear");
    for (i = 0; i < 2; i++) begin
      aux(i ? gah_pkg::FC_RET_LOCAL : gah_pkg::FC_FORCE_TRIG, 1'b0);
      check({i ? rp : tp, i ? return_local : trigger_out}, 2'h2, "pulse on clear");
      aux(i ? gah_pkg::FC_RET_LOCAL : gah_pkg::FC_FORCE_TRIG, 1'b1);
      check(i ? return_local : trigger_out, 1'b1, "feature set");
      aux(i ? gah_pkg::FC_RET_LOCAL : gah_pkg::FC_FORCE_TRIG, 1'b0);
      check({i ? rp : tp, i ? return_local : trigger_out}, 2'h0, "clear no pulse");
    end
    $display("test features done");
    for (i = 0; i < gah_pkg::FIFO_DEPTH; i++) begin
      b[i] = 8'($random(seed));
      seen = '0;
      gah_talker_i.send(b[i], 1'b0, 1'b0, $random(seed) & 3, ok);
      check({ok, rfd_holdoff_data_latch, seen.byte_in_irq}, 3'h7, "byte in");
      aux(gah_pkg::FC_REL_RFD, 1'b0);
      check(rfd_holdoff_data_latch, 1'b0, "rfd release");
    end
    gah_talker_i.send(8'h5A, 1'b0, 1'b0, 0, ok);
    check(ok, 1'b0, "full fifo refuses");
    for (i = 0; i < gah_pkg::FIFO_DEPTH; i++) pop({1'b0, b[i]});
    check(rx_valid, 1'b0, "fifo empty");
    $display("test fifo done");
    aux(gah_pkg::FC_HOLD_ALL, 1'b1);
    gah_talker_i.send(8'h3C, 1'b0, 1'b0, 0, ok);
    pop(9'h03C);
    check(rfd_holdoff_data_latch, 1'b1, "read keeps latch");
    aux(gah_pkg::FC_REL_RFD, 1'b0);
    check(rfd_holdoff_data_latch, 1'b0, "release clears");
    aux(gah_pkg::FC_HOLD_ALL, 1'b0);
    aux(gah_pkg::FC_HOLD_END, 1'b1);
    seen = '0;
    gah_talker_i.send(8'hC3, 1'b0, 1'b1, 0, ok);
    check({rfd_holdoff_end_latch, seen.end_irq}, 2'h3, "end byte");
    pop(9'h1C3);
    repeat (2) @(posedge clk);
    #1;
    check({rfd_holdoff_end_latch, rfd}, 2'h2, "end holds rfd");
    aux(gah_pkg::FC_REL_RFD, 1'b0);
    check(rfd_holdoff_end_latch, 1'b0, "end release");
    aux(gah_pkg::FC_HOLD_END, 1'b0);
    $display("test holdoffs done");
    for (i = 0; i < 6; i++) begin
      for (k = 0; k < 2; k++) begin
        e = irq_of(cl[i]);
        irq_mask = k ? 8'hFF : ~e;
        seen = '0;
        gah_talker_i.send({1'b0, cl[i]}, 1'b1, 1'b0, k, ok);
        if (k) begin
          check({ok, dac, dac_holdoff_latch, dio_out}, 11'h100, "dac holdoff");
          check(trigger_out, cl[i] == gah_pkg::CMD_GET, "trigger held");
          aux(gah_pkg::FC_REL_DAC, i[0]);
          check({sec_addr_valid, dac_holdoff_latch}, {i[0], 1'b0}, "dac release");
          gah_talker_i.finish(ok);
        end
        check({ok, dac_holdoff_latch, trigger_out, rx_valid}, 4'h8, "command done");
        check(seen & e, e, "command event");
      end
    end
    irq_mask = 8'hFF;
    $display("test commands done");
    cacs = 1;
    repeat (2) @(posedge clk);
    #1;
    check({rfd, dac, dio_out}, 10'h300, "idle in cacs");
    cacs = 0;
    gah_talker_i.send(8'h77, 1'b0, 1'b0, 0, ok);
    check(ok, 1'b1, "byte before soft reset");
    aux(gah_pkg::FC_SOFT_RESET, 1'b1);
    check({rfd, dac, rfd_holdoff_data_latch}, 3'h6, "soft reset idle");
    aux(gah_pkg::FC_SOFT_RESET, 1'b0);
    pop(9'h077);
    aux(gah_pkg::FC_FORCE_TRIG, 1'b1);
    do_reset();
    $display("test resets done");
    results();
  end
endmodule // testbench
